// [shared/fms_defs.vh]
// Constants of the fan module supervisor: register map, fields, variants, timing.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone register bus.
`ifndef FMS_DEFS_VH
`define FMS_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define FMS_REG_CTRL      8'h00
`define FMS_REG_STATE     8'h04
`define FMS_REG_FLAGS     8'h08
`define FMS_REG_EVENT     8'h0C
`define FMS_REG_IRQ_STAT  8'h10
`define FMS_REG_IRQ_MASK  8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define FMS_CTRL_VAR_LSB  0
`define FMS_CTRL_RUN_BIT  2
`define FMS_FLG_WARN      0
`define FMS_FLG_SPARE     1
`define FMS_FLG_FAULT     2
`define FMS_IRQ_EVENT     0
`define FMS_IRQ_DIAG      1
`define FMS_IRQ_HALT      2
`define FMS_IRQ_W         3

// ****************************************************************
// Variant codes and reset values
// ****************************************************************
`define FMS_VAR_OPTIONAL  2'h0
`define FMS_VAR_SINGLE    2'h1
`define FMS_VAR_DOUBLE    2'h2
`define FMS_CTRL_RST      3'h0

// ****************************************************************
// Event codes
// ****************************************************************
`define FMS_EVT_CODE      8'hCD
`define FMS_DET_ALL_FANS  32'h00000080
`define FMS_DET_SPARE_FAN 32'h00004000
`define FMS_DIAG_NO_FAN   2'h1
`define FMS_DIAG_SPARE    2'h2

// ****************************************************************
// Display codes
// ****************************************************************
`define FMS_SEG_F         4'hF
`define FMS_SEG_8         4'h8
`define FMS_SEG_RUN       4'h0

// ****************************************************************
// Timing
// ****************************************************************
`define FMS_CLK_HZ        10000000
`define FMS_BLINK_HZ      2
`define FMS_TOUT_S        60
// Half period of the 2 Hz blink, in clocks
`define FMS_BLINK_HALF    (`FMS_CLK_HZ / (2 * `FMS_BLINK_HZ))
`define FMS_TOUT_CYC      (`FMS_CLK_HZ * `FMS_TOUT_S)

`endif

// [hw/fms_sync.v]
// Two-stage synchroniser for a group of single-bit levels.
// Assumes the inputs are static for at least two clocks.
`timescale 1ns/100ps

module fms_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // Levels
   input  wire [W-1:0] async_i,
   output reg  [W-1:0] sync_o
);

   reg [W-1:0] meta;

   // First stage feeds only the second stage
   always @(posedge clk_i) begin
      if (rst_i) begin
         meta   <= {W{1'b0}};
         sync_o <= {W{1'b0}};
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule // fms_sync

// [hw/fms_prescale.v]
// Free prescaler: one-cycle tick every LIMIT clocks while enabled.
// Assumes LIMIT of at least one.
`timescale 1ns/100ps

module fms_prescale #(
   parameter W     = 32,
   parameter LIMIT = 1
) (
   // Clock and reset
   input  wire clk_i,
   input  wire rst_i,
   // Control
   input  wire run_i,
   output reg  tick_o
);

   localparam [W-1:0] LAST = LIMIT - 1;

   reg [W-1:0] count;

   always @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         count  <= {W{1'b0}};
         tick_o <= 1'b0;
      end else if (count == LAST) begin
         count  <= {W{1'b0}};
         tick_o <= 1'b1;
      end else begin
         count  <= count + {{(W-1){1'b0}}, 1'b1};
         tick_o <= 1'b0;
      end
   end

endmodule // fms_prescale

// [hw/fms_top.v]
// Fan module supervisor: fan switching, power-up test, fault states, status registers.
// Assumes synchronous active-high reset is the power cycle; only it clears halt states.
// Operation
// - Double variant runs fan continuously at about 40 C or above.
// - Mandatory variants blink ready indicator red/yellow 2 Hz on fan failure.
// - Fan fault records diagnostic entry, sets fan flag, raises fault event only in RUN.
// - Optional variant sets fan warning flag when module absent at power-on.
// - Optional variant raises no fault event when module absent at start.
// - Optional variant keeps running after fan failure until overtemperature.
// - Second threshold enters FAULT: shows F, all indicators flicker red, latched.
// - Single mandatory variant tests module at power-up; failure withholds kernel.
// - Single variant without working fan enters RESET after one minute, shows 8.
// - Double variant with one fan failed drives remaining fan full load, raises event in RUN.
// - Double variant power-up passes if one fan works, else withholds kernel.
// - Double variant needing cooling without working fan enters RESET after minute.
// - Double module is functional with one fan, defective only with none.
// - Spare fan failing in RUN raises event code 205, detail 16#00004000.
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "fms_defs.vh"

module fms_top #(
   parameter BLINK_HALF = `FMS_BLINK_HALF,
   parameter TOUT_CYC   = `FMS_TOUT_CYC
) (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output wire        ack_o,
   // Fan module
   input  wire        temp_43_i,
   input  wire        temp_40_i,
   input  wire        temp_hi2_i,
   input  wire        present_i,
   input  wire        fan0_ok_i,
   input  wire        fan1_ok_i,
   output reg         fan_on_o,
   output reg         fan_full_o,
   // Indicators
   output reg         rdy_red_o,
   output reg         rdy_yel_o,
   output reg         all_red_o,
   output reg  [3:0]  seg_o,
   output reg         kernel_ok_o,
   // Interrupt
   output wire        irq_o
);

   // ****************************************************************
   // States
   // ****************************************************************
   localparam [5:0] ST_TEST  = 6'h01;
   localparam [5:0] ST_STOP  = 6'h02;
   localparam [5:0] ST_RUN   = 6'h04;
   localparam [5:0] ST_HOLD  = 6'h08;
   localparam [5:0] ST_FAULT = 6'h10;
   localparam [5:0] ST_RESET = 6'h20;

   // ****************************************************************
   // Input synchronisation
   // ****************************************************************
   wire [5:0] s;
   fms_sync #(.W(6)) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({temp_hi2_i, temp_40_i, temp_43_i, present_i, fan1_ok_i, fan0_ok_i}),
      .sync_o  (s)
   );
   wire f0   = s[0];
   wire f1   = s[1];
   wire pres = s[2];
   wire t43  = s[3];
   wire t40  = s[4];
   wire thi2 = s[5];

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg  [2:0]  ctrl;
   reg  [5:0]  state;
   reg  [2:0]  flags;
   reg  [31:0] detail;
   reg  [1:0]  diag;
   reg  [2:0]  irq_stat;
   reg  [2:0]  irq_mask;
   reg         ack;
   reg         blink;
   reg         was_pres;
   reg         spare_seen;
   reg         all_seen;
   reg  [1:0]  settle;
   reg         cfg;

   wire [1:0] variant = ctrl[`FMS_CTRL_VAR_LSB+1:`FMS_CTRL_VAR_LSB];
   wire       go_run  = ctrl[`FMS_CTRL_RUN_BIT];
   wire       is_opt  = (variant == `FMS_VAR_OPTIONAL);
   wire       is_dbl  = (variant == `FMS_VAR_DOUBLE);

   // module present and functional: any working fan in double variant, else fan 0
   wire mod_ok    = pres && (is_dbl ? (f0 || f1) : f0);
   wire spare_bad = is_dbl && pres && (f0 ^ f1);
   wire cool_need = is_dbl ? t40 : 1'b1;
   // test waits for settled inputs and a written variant, as reset clears it
   wire test_done = (settle == 2'h2) && cfg;

   // ****************************************************************
   // Prescalers
   // ****************************************************************
   wire blink_tick;
   wire tout_tick;
   fms_prescale #(.W(32), .LIMIT(BLINK_HALF)) u_blink (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (1'b1),
      .tick_o (blink_tick)
   );
   // timeout runs while no working cooling
   // double variant counts only when cooling is demanded
   // timeout prescaler, restarts when cooling returns
   fms_prescale #(.W(32), .LIMIT(TOUT_CYC)) u_tout (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (state == ST_RUN && !is_opt && !mod_ok && cool_need),
      .tick_o (tout_tick)
   );

   always @(posedge clk_i) begin
      if (rst_i) begin
         blink <= 1'b0;
      end else if (blink_tick) begin
         blink <= ~blink;
      end
   end

   // ****************************************************************
   // Supervisor state machine
   // ****************************************************************
   reg [5:0] next_state;
   always @* begin
      next_state = state;
      case (state)
         ST_TEST: begin
            if (!test_done) begin
               next_state = ST_TEST;
            end else if (is_opt || mod_ok) begin
               next_state = ST_STOP;
            end else begin
               next_state = ST_HOLD;
            end
         end
         ST_STOP: begin
            if (go_run) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (tout_tick) begin
               next_state = ST_RESET;
            end else if (!go_run) begin
               next_state = ST_STOP;
            end
         end
         ST_HOLD:  next_state = ST_HOLD;
         ST_FAULT: next_state = ST_FAULT;
         ST_RESET: next_state = ST_RESET;
         default:  next_state = ST_TEST;
      endcase
      // overtemperature wins outside TEST and RESET, latched until power cycle
      // only overtemperature stops the optional variant
      if (thi2 && state != ST_TEST && state != ST_RESET) begin
         next_state = ST_FAULT;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state  <= ST_TEST;
         settle <= 2'h0;
      end else begin
         state <= next_state;
         // Synchroniser is cleared by reset, so its output is stale for two clocks
         if (settle != 2'h2) begin
            settle <= settle + 2'h1;
         end
      end
   end

   // ****************************************************************
   // Fault detection and events
   // ****************************************************************
   wire in_run   = (state == ST_RUN);
   wire live     = (state == ST_STOP) || in_run;
   wire new_all  = live && !mod_ok && !all_seen;
   wire new_spr  = live && spare_bad && !spare_seen;
   // absent at start in optional variant gives no event
   wire opt_mute = is_opt && !was_pres;
   // event on fan fault during run
   wire ev_all   = in_run && new_all && !opt_mute;
   wire ev_spr   = in_run && new_spr;
   wire ev_any   = ev_all || ev_spr;
   wire halt_now = (next_state != state) && (next_state == ST_HOLD ||
                    next_state == ST_FAULT || next_state == ST_RESET);

   // Bus read of the status register, used for clear-on-read
   wire bus_req  = cyc_i && stb_i && !ack;
   wire rd_irq   = bus_req && !we_i && (adr_i == `FMS_REG_IRQ_STAT);
   wire wr_ctrl  = bus_req && we_i && (adr_i == `FMS_REG_CTRL) && sel_i[0];
   wire wr_flags = bus_req && we_i && (adr_i == `FMS_REG_FLAGS) && sel_i[0];
   wire wr_mask  = bus_req && we_i && (adr_i == `FMS_REG_IRQ_MASK) && sel_i[0];
   wire [2:0] irq_set = {halt_now, (new_all || new_spr), ev_any};

   always @(posedge clk_i) begin
      if (rst_i) begin
         flags      <= 3'h0;
         detail     <= 32'h00000000;
         diag       <= 2'h0;
         was_pres   <= 1'b0;
         spare_seen <= 1'b0;
         all_seen   <= 1'b0;
         irq_stat   <= 3'h0;
      end else begin
         if (state == ST_TEST) begin
            was_pres <= pres;
            if (test_done && is_opt && !pres) begin
               flags[`FMS_FLG_WARN] <= 1'b1;
            end
         end
         // software clears flags; fault sets win over clear, the power-up warning set does not
         if (wr_flags) begin
            flags <= flags & ~dat_i[2:0];
         end
         if (new_all) begin
            all_seen             <= 1'b1;
            diag                 <= `FMS_DIAG_NO_FAN;
            flags[`FMS_FLG_WARN] <= 1'b1;
         end else if (new_spr) begin
            spare_seen            <= 1'b1;
            diag                  <= `FMS_DIAG_SPARE;
            flags[`FMS_FLG_SPARE] <= 1'b1;
         end
         if (ev_all) begin
            detail                <= `FMS_DET_ALL_FANS;
            flags[`FMS_FLG_FAULT] <= 1'b1;
         end else if (ev_spr) begin
            detail                <= `FMS_DET_SPARE_FAN;
            flags[`FMS_FLG_FAULT] <= 1'b1;
         end
         irq_stat <= (rd_irq ? 3'h0 : irq_stat) | irq_set;
      end
   end

   assign irq_o = |(irq_stat & irq_mask);

   // ****************************************************************
   // Fan drive and indicators
   // ****************************************************************
   always @(posedge clk_i) begin
      if (rst_i) begin
         fan_on_o    <= 1'b0;
         fan_full_o  <= 1'b0;
         rdy_red_o   <= 1'b0;
         rdy_yel_o   <= 1'b0;
         all_red_o   <= 1'b0;
         seg_o       <= `FMS_SEG_RUN;
         kernel_ok_o <= 1'b0;
      end else begin
         case (variant)
            `FMS_VAR_OPTIONAL: fan_on_o <= t43;
            // double fan continuous at 40 C
            `FMS_VAR_DOUBLE:   fan_on_o <= t40;
            default:           fan_on_o <= 1'b1;
         endcase
         fan_full_o  <= spare_bad;
         kernel_ok_o <= live;
         // red/yellow 2 Hz on mandatory fan loss
         if (state == ST_HOLD || (live && !is_opt && !mod_ok)) begin
            rdy_red_o <= blink;
            rdy_yel_o <= ~blink;
         end else begin
            rdy_red_o <= 1'b0;
            rdy_yel_o <= live;
         end
         all_red_o <= (state == ST_FAULT) && blink;
         case (state)
            ST_FAULT: seg_o <= `FMS_SEG_F;
            ST_RESET: seg_o <= `FMS_SEG_8;
            default:  seg_o <= `FMS_SEG_RUN;
         endcase
      end
   end

   // ****************************************************************
   // Wishbone slave: one wait state, unmapped reads zero
   // ****************************************************************
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack      <= 1'b0;
         dat_o    <= 32'h00000000;
         ctrl     <= `FMS_CTRL_RST;
         irq_mask <= 3'h0;
         cfg      <= 1'b0;
      end else begin
         ack <= bus_req;
         if (wr_ctrl) begin
            ctrl <= dat_i[2:0];
            cfg  <= 1'b1;
         end
         if (wr_mask) begin
            irq_mask <= dat_i[2:0];
         end
         case (adr_i)
            `FMS_REG_CTRL:     dat_o <= {29'h0, ctrl};
            `FMS_REG_STATE:    dat_o <= {26'h0, state};
            `FMS_REG_FLAGS:    dat_o <= {27'h0, diag, flags};
            `FMS_REG_EVENT:    dat_o <= (detail == 32'h0) ? 32'h0 :
                                        {`FMS_EVT_CODE, detail[23:0]};
            `FMS_REG_IRQ_STAT: dat_o <= {29'h0, irq_stat};
            `FMS_REG_IRQ_MASK: dat_o <= {29'h0, irq_mask};
            default:           dat_o <= 32'h00000000;
         endcase
      end
   end

   assign ack_o = ack;

endmodule // fms_top

// [testbench/fms_fan_model.sv]
// Behavioural fan module: temperature comparators and fan health lines.
// Assumes the bench sets the air temperature and the fan faults.
`timescale 1ns/100ps

module fms_fan_model #(
   parameter HI2_C = 60
) (
   // Bench controls
   input  wire [7:0] temp_c_i,
   input  wire       plug_i,
   input  wire       good0_i,
   input  wire       good1_i,
   input  wire       dbl_i,
   // Lines to the supervisor
   output wire       temp_40_o,
   output wire       temp_43_o,
   output wire       temp_hi2_o,
   output wire       present_o,
   output wire       fan1_ok_o,
   output wire       fan0_ok_o
);
   assign temp_40_o  = (temp_c_i >= 8'd40);
   assign temp_43_o  = (temp_c_i >= 8'd43);
   assign temp_hi2_o = (temp_c_i >= HI2_C);
   // Health lines are pulled low when the module is unplugged
   assign present_o  = plug_i;
   assign fan0_ok_o  = plug_i & good0_i;
   assign fan1_ok_o  = plug_i & good1_i & dbl_i;
endmodule // fms_fan_model

// [testbench/fms_top_sva.sv]
// Checker on the ports of the fan module supervisor.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/100ps

module fms_top_sva (
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // Bus and fan lines
   input  wire       cyc_i,
   input  wire       stb_i,
   input  wire       ack_o,
   input  wire       temp_hi2_i,
   input  wire       fan0_ok_i,
   input  wire       fan1_ok_i,
   // Outputs
   input  wire       fan_full_o,
   input  wire       rdy_red_o,
   input  wire       rdy_yel_o,
   input  wire       kernel_ok_o,
   input  wire [3:0] seg_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_ack_lat;
      (cyc_i && stb_i && !ack_o) |=> ack_o;
   endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late"); // bus timing
   property p_ack_pulse;
      ack_o |=> !ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held"); // bus timing
   property p_fault_hold;
      (seg_o == 4'hF) |=> (seg_o == 4'hF);
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault left");
   property p_fault_cause;
      $rose(seg_o == 4'hF) |-> ($past(temp_hi2_i, 2) || $past(temp_hi2_i, 3));
   endproperty
   a_fault_cause: assert property (p_fault_cause) else $error("fault uncaused");
   property p_fault_kernel;
      (seg_o == 4'hF) |-> !kernel_ok_o;
   endproperty
   a_fault_kernel: assert property (p_fault_kernel) else $error("kernel in fault");
   property p_reset_hold;
      (seg_o == 4'h8) |=> (seg_o == 4'h8) [*3];
   endproperty
   a_reset_hold: assert property (p_reset_hold) else $error("reset left");
   property p_blink_excl;
      !(rdy_red_o && rdy_yel_o);
   endproperty
   a_blink_excl: assert property (p_blink_excl) else $error("red and yellow");
   property p_full_cause;
      $rose(fan_full_o) |-> !$past(fan0_ok_i && fan1_ok_i, 3);
   endproperty
   a_full_cause: assert property (p_full_cause) else $error("full load uncaused");
endmodule // fms_top_sva

bind fms_top fms_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .ack_o(ack_o), .temp_hi2_i(temp_hi2_i), .fan0_ok_i(fan0_ok_i), .fan1_ok_i(fan1_ok_i),
   .fan_full_o(fan_full_o), .rdy_red_o(rdy_red_o), .rdy_yel_o(rdy_yel_o),
   .kernel_ok_o(kernel_ok_o), .seg_o(seg_o));

// [testbench/fms_top_tb.sv]
// Self-checking bench of the fan module supervisor over Wishbone.
// Assumes short prescaler counts; expected reads queue for the monitor.
`timescale 1ns/100ps
`include "fms_defs.vh"
`define CHK(g, e) begin tests_run = tests_run + 1; if ((g) !== (e)) begin \
   num_errors = num_errors + 1; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module fms_top_tb;
   localparam BH = 4;
   localparam TO = 50;
   localparam [31:0] ALL = 32'hFFFFFFFF;
   reg         clk_i, rst_i, cyc_i, stb_i, we_i;
   reg  [7:0]  adr_i, temp_c;
   reg  [31:0] dat_i;
   reg         plug, good0, good1, dbl;
   wire [31:0] dat_o;
   wire [3:0]  seg_o;
   wire        ack_o, t40, t43, thi, pres, ok0, ok1, fan_on_o, fan_full_o;
   wire        rdy_red_o, rdy_yel_o, all_red_o, kernel_ok_o, irq_o;
   reg  [63:0] exp_q[$];
   reg  [63:0] note;
   integer     num_errors, tests_run, cycles, r, y, seed;
   wire [31:0] ev_all = {`FMS_EVT_CODE, 24'h0} | `FMS_DET_ALL_FANS;
   wire [31:0] ev_spr = {`FMS_EVT_CODE, 24'h0} | `FMS_DET_SPARE_FAN;

   fms_fan_model u_fan (.temp_c_i(temp_c), .plug_i(plug), .good0_i(good0), .good1_i(good1),
      .dbl_i(dbl), .temp_40_o(t40), .temp_43_o(t43), .temp_hi2_o(thi), .present_o(pres),
      .fan0_ok_o(ok0), .fan1_ok_o(ok1));
   fms_top #(.BLINK_HALF(BH), .TOUT_CYC(TO)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .temp_43_i(t43), .temp_40_i(t40), .temp_hi2_i(thi), .present_i(pres),
      .fan0_ok_i(ok0), .fan1_ok_i(ok1), .fan_on_o(fan_on_o), .fan_full_o(fan_full_o),
      .rdy_red_o(rdy_red_o), .rdy_yel_o(rdy_yel_o), .all_red_o(all_red_o), .seg_o(seg_o),
      .kernel_ok_o(kernel_ok_o), .irq_o(irq_o));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task summarize;
      begin
         $display("Errors %0d of %0d checks", num_errors, tests_run);
         if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   // A read queues {mask, expected}; the monitor compares at ack
   task wb(input w, input [7:0] a, input [31:0] d, input [31:0] m);
      integer n;
      begin
         n = 0;
         @(posedge clk_i);
         cyc_i <= 1'b1;
         stb_i <= 1'b1;
         we_i  <= w;
         adr_i <= a;
         dat_i <= d;
         if (!w) exp_q.push_back({m, d});
         do begin
            @(posedge clk_i);
            n = n + 1;
         end while (ack_o !== 1'b1 && n < 100);
         if (n >= 100) num_errors = num_errors + 1;
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
         we_i  <= 1'b0;
      end
   endtask

   task pause(input integer n);
      repeat (n) @(posedge clk_i);
   endtask

   task power_up;
      begin
         @(posedge clk_i);
         rst_i <= 1'b1;
         pause(12);
         rst_i <= 1'b0;
      end
   endtask

   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && !we_i && exp_q.size() > 0) begin
         note = exp_q.pop_front();
         `CHK(dat_o & note[63:32], note[31:0]) // register read
      end
      cycles = cycles + 1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         summarize;
      end
   end

   initial begin
      {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i} = 0;
      {num_errors, tests_run, cycles} = 0;
      seed = $urandom(32'h02E9);
      // Optional variant powered up without a module
      {plug, good0, good1, dbl} <= 4'b0110;
      temp_c <= 8'd20 + 8'($urandom % 20);
      power_up;
      wb(1, `FMS_REG_CTRL, 32'h0, 0);
      wb(0, `FMS_REG_CTRL, 32'h0, ALL);
      wb(0, `FMS_REG_STATE, 32'h2, ALL);
      wb(0, `FMS_REG_FLAGS, 32'h1, 32'h1);
      wb(0, `FMS_REG_EVENT, 32'h0, ALL);
      wb(0, `FMS_REG_IRQ_STAT, 32'h0, 32'h1);
      wb(1, 8'h20, $urandom, 0);
      wb(0, 8'h20, 32'h0, ALL);
      wb(1, `FMS_REG_FLAGS, 32'h1, 0);
      wb(0, `FMS_REG_FLAGS, 32'h0, 32'h1);
      wb(1, `FMS_REG_CTRL, 32'h4, 0);
      wb(0, `FMS_REG_STATE, 32'h4, ALL);
      temp_c <= 8'd43 + 8'($urandom % 10);
      pause(5);
      `CHK(fan_on_o, 1'b1)
      temp_c <= 8'd40 + 8'($urandom % 3);
      pause(5);
      `CHK(fan_on_o, 1'b0)
      wb(0, `FMS_REG_EVENT, 32'h0, ALL);
      temp_c <= 8'd90;
      pause(5);
      `CHK(seg_o, `FMS_SEG_F)
      r = 0;
      repeat (16) @(posedge clk_i) r = r + all_red_o;
      `CHK(r > 0, 1'b1)
      wb(1, `FMS_REG_CTRL, 32'h0, 0);
      wb(0, `FMS_REG_STATE, 32'h10, ALL);
      // Double fan: spare lost, then both lost
      {plug, good0, good1, dbl} <= 4'b1111;
      temp_c <= 8'd40 + 8'($urandom % 3);
      power_up;
      wb(1, `FMS_REG_CTRL, 32'h6, 0);
      pause(5);
      `CHK(fan_on_o, 1'b1)
      good1 <= 1'b0;
      pause(5);
      `CHK(fan_full_o, 1'b1)
      `CHK(irq_o, 1'b0)
      wb(0, `FMS_REG_EVENT, ev_spr, ALL);
      wb(0, `FMS_REG_FLAGS, 32'h2, 32'h3);
      wb(0, `FMS_REG_STATE, 32'h4, ALL);
      wb(1, `FMS_REG_IRQ_MASK, 32'h3, 0);
      `CHK(irq_o, 1'b1)
      wb(0, `FMS_REG_IRQ_STAT, 32'h1, 32'h1);
      `CHK(irq_o, 1'b0)
      good0 <= 1'b0;
      pause(5);
      wb(0, `FMS_REG_EVENT, ev_all, ALL);
      wb(0, `FMS_REG_FLAGS, 32'h1, 32'h1);
      {r, y} = 0;
      repeat (2 * BH) @(posedge clk_i) begin
         r = r + rdy_red_o;
         y = y + rdy_yel_o;
      end
      `CHK(r, BH)
      `CHK(y, BH)
      pause(TO + 10);
      wb(0, `FMS_REG_STATE, 32'h20, ALL);
      `CHK(seg_o, `FMS_SEG_8)
      // Single mandatory fan lost in run
      {plug, good0, good1, dbl} <= 4'b1100;
      temp_c <= 8'd20 + 8'($urandom % 30);
      power_up;
      wb(1, `FMS_REG_CTRL, 32'h5, 0);
      good0 <= 1'b0;
      pause(5);
      wb(0, `FMS_REG_EVENT, ev_all, ALL);
      wb(0, `FMS_REG_STATE, 32'h4, ALL);
      pause(TO + 10);
      wb(0, `FMS_REG_STATE, 32'h20, ALL);
      `CHK(seg_o, `FMS_SEG_8)
      // Mandatory variants that fail the power-up test withhold the kernel
      {plug, good0, good1, dbl} <= 4'b0000;
      power_up;
      wb(1, `FMS_REG_CTRL, 32'h1, 0);
      wb(0, `FMS_REG_STATE, 32'h8, ALL);
      `CHK(kernel_ok_o, 1'b0)
      {plug, good0, good1, dbl} <= 4'b1001;
      power_up;
      wb(1, `FMS_REG_CTRL, 32'h2, 0);
      wb(0, `FMS_REG_STATE, 32'h8, ALL);
      `CHK(kernel_ok_o, 1'b0)
      pause(2);
      summarize;
   end
endmodule // fms_top_tb
